// ===== logic/dbu_pkg.sv
// Contract
// - four breakpoint address registers, each with type, length, enables in control.
// - access of configured type hitting a breakpoint raises a debug exception.
// - length code 00 one byte, 01 two bytes, 11 four bytes, 10 unused.
// - type code 00 execute, 01 data write, 11 data read or write, 10 unused.
// - execution breakpoints trap before the matching instruction executes.
// - debug register moves allowed only at privilege level 0.
// - status is never cleared by hardware after an exception.
// - per-breakpoint match flag set at exception time, even when disabled.
// - task-switch flag set before handler entry when new task has trap bit.
// - single-step flag set when the exception came from single-step.
// - trap flag set raises a debug exception after every executed instruction.
// - global enable covers all tasks and survives a task switch.
// - local enable covers current task only and is cleared on task switch.
// - access-disable control blocks register moves, cleared on any debug exception.
// - breakpoint trap instruction raises a debug exception regardless of addresses.
package dbu_pkg;

  localparam int NUM_BP = 4;

  // =========================================================
  // register numbers of the move instruction
  localparam logic [2:0] REG_BP0 = 3'h0;
  localparam logic [2:0] REG_BP1 = 3'h1;
  localparam logic [2:0] REG_BP2 = 3'h2;
  localparam logic [2:0] REG_BP3 = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h6;
  localparam logic [2:0] REG_CONTROL = 3'h7;

  // =========================================================
  // control field layout
  localparam int CTL_EN_STRIDE = 2;
  localparam int CTL_GD_BIT = 13;
  localparam int CTL_FLD_BASE = 16;
  localparam int CTL_FLD_STRIDE = 4;
  localparam logic [31:0] CTL_LOCAL_MASK = 32'h0000_0055;
  localparam logic [31:0] CTL_GLOBAL_MASK = 32'h0000_00aa;
  localparam logic [31:0] CTL_WMASK = 32'hffff_20ff;

  // =========================================================
  // status field layout
  localparam int STS_BS_BIT = 14;
  localparam int STS_BT_BIT = 15;
  localparam logic [31:0] STS_WMASK = 32'h0000_c00f;

  // =========================================================
  // reset values
  localparam logic [31:0] BP_RESET = 32'h0000_0000;
  localparam logic [31:0] STS_RESET = 32'h0000_0000;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  // =========================================================
  // field encodings
  localparam logic [1:0] TYPE_EXEC = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1;
  localparam logic [1:0] TYPE_RDWR = 2'h3;
  localparam logic [1:0] LEN_1 = 2'h0;
  localparam logic [1:0] LEN_2 = 2'h1;
  localparam logic [1:0] LEN_4 = 2'h3;
  localparam logic [31:0] MASK_1 = 32'hffff_ffff;
  localparam logic [31:0] MASK_2 = 32'hffff_fffe;
  localparam logic [31:0] MASK_4 = 32'hffff_fffc;

  // =========================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic int3;
    logic [31:0] addr;
  } dbu_insn_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } dbu_data_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] idx;
    logic [31:0] wdata;
  } dbu_mov_req_t;

  typedef struct packed {
    logic ack;
    logic fault;
    logic [31:0] rdata;
  } dbu_mov_rsp_t;

  typedef struct packed {
    logic code;
    logic int3;
    logic step;
    logic task_trap;
    logic gd;
    logic data;
  } dbu_cause_t;

  typedef struct packed {
    logic [NUM_BP-1:0][31:0] bp_addr;
    logic [31:0] status;
    logic [31:0] control;
    logic exc;
    dbu_cause_t cause;
    dbu_mov_rsp_t rsp;
  } dbu_state_t;

  localparam dbu_state_t STATE_RESET = '{
    bp_addr: {NUM_BP{BP_RESET}},
    status: STS_RESET,
    control: CTL_RESET,
    exc: 1'b0,
    cause: '0,
    rsp: '0
  };

endpackage : dbu_pkg

// ===== logic/dbu_match.sv
`timescale 1ns/1ns
module dbu_match
  import dbu_pkg::*;
(
  // breakpoint setup
  input wire logic [31:0] bp_addr_i,
  input wire logic [1:0] type_i,
  input wire logic [1:0] len_i,
  // accesses
  input wire dbu_insn_t insn_i,
  input wire dbu_data_t data_i,
  // match results
  output logic code_hit_o,
  output logic data_hit_o
);

  logic [31:0] mask;
  logic len_ok;
  logic code_eq;
  logic data_eq;

  // =========================================================
  // span mask, low bits ignored per length
  always_comb begin
    len_ok = 1'b1;
    case (len_i)
      LEN_1: mask = MASK_1;
      LEN_2: mask = MASK_2;
      LEN_4: mask = MASK_4;
      default: begin
        mask = MASK_1;
        len_ok = 1'b0;
      end
    endcase
  end

  assign code_eq = ((insn_i.addr ^ bp_addr_i) & mask) == 32'h0000_0000;
  assign data_eq = ((data_i.addr ^ bp_addr_i) & mask) == 32'h0000_0000;

  // =========================================================
  // type qualification
  assign code_hit_o = insn_i.valid & len_ok & (type_i == TYPE_EXEC) & code_eq;
  assign data_hit_o = data_i.valid & len_ok & data_eq &
                      ((type_i == TYPE_RDWR) | ((type_i == TYPE_WRITE) & data_i.write));

endmodule : dbu_match

// ===== logic/dbu_core.sv
`timescale 1ns/1ns
module dbu_core
  import dbu_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // privilege and register moves
  input wire logic [1:0] cpl_i,
  input wire dbu_mov_req_t mov_i,
  output dbu_mov_rsp_t mov_o,
  // instruction issue and retire
  input wire dbu_insn_t insn_i,
  input wire logic retire_i,
  input wire logic trap_flag_i,
  output logic issue_block_o,
  // data accesses
  input wire dbu_data_t data_i,
  // task switches
  input wire logic task_switch_i,
  input wire logic task_trap_i,
  // exception toward the core
  output logic debug_exc_o,
  output dbu_cause_t cause_o
);

  dbu_state_t s;
  dbu_state_t next_s;
  dbu_cause_t cause;
  logic [NUM_BP-1:0] code_cond;
  logic [NUM_BP-1:0] data_cond;
  logic [NUM_BP-1:0] bp_en;
  logic code_hit;
  logic priv_ok;
  logic gd_set;
  logic mov_fault;
  logic gd_viol;
  logic mov_ok;
  logic exc_now;
  logic [31:0] rd_val;
  logic [31:0] sts_set;
  logic sts_bs_wr;

  // =========================================================
  // per-breakpoint comparators
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BP; gi = gi + 1) begin : g_bp
      dbu_match u_match (
        .bp_addr_i(s.bp_addr[gi]),
        .type_i(s.control[CTL_FLD_BASE + CTL_FLD_STRIDE*gi +: 2]),
        .len_i(s.control[CTL_FLD_BASE + CTL_FLD_STRIDE*gi + 2 +: 2]),
        .insn_i(insn_i),
        .data_i(data_i),
        .code_hit_o(code_cond[gi]),
        .data_hit_o(data_cond[gi])
      );
      // local or global enable arms the breakpoint
      assign bp_en[gi] = s.control[CTL_EN_STRIDE*gi] | s.control[CTL_EN_STRIDE*gi + 1];
    end
  endgenerate

  // =========================================================
  // exception causes
  assign code_hit = |(code_cond & bp_en);
  assign issue_block_o = code_hit;
  assign priv_ok = cpl_i == 2'h0;
  assign gd_set = s.control[CTL_GD_BIT];
  assign mov_fault = mov_i.valid & ~priv_ok;
  assign gd_viol = mov_i.valid & priv_ok & gd_set;
  assign mov_ok = mov_i.valid & priv_ok & ~gd_set;

  always_comb begin
    cause = '0;
    cause.code = code_hit;
    cause.int3 = insn_i.valid & insn_i.int3 & ~code_hit;
    cause.step = retire_i & trap_flag_i;
    cause.task_trap = task_switch_i & task_trap_i;
    cause.gd = gd_viol;
    cause.data = |(data_cond & bp_en);
  end

  assign exc_now = |cause;

  // =========================================================
  // register read mux
  always_comb begin
    case (mov_i.idx)
      REG_BP0: rd_val = s.bp_addr[0];
      REG_BP1: rd_val = s.bp_addr[1];
      REG_BP2: rd_val = s.bp_addr[2];
      REG_BP3: rd_val = s.bp_addr[3];
      REG_STATUS: rd_val = s.status;
      REG_CONTROL: rd_val = s.control;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // status bits raised with an exception
  always_comb begin
    sts_set = 32'h0000_0000;
    sts_set[NUM_BP-1:0] = code_cond | data_cond;
    sts_set[STS_BS_BIT] = cause.step;
    sts_set[STS_BT_BIT] = cause.task_trap;
  end

  // =========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.rsp.ack = mov_ok | mov_fault;
    next_s.rsp.fault = mov_fault;
    next_s.rsp.rdata = 32'h0000_0000;
    if (mov_ok && !mov_i.write) begin
      next_s.rsp.rdata = rd_val;
    end
    if (mov_ok && mov_i.write) begin
      case (mov_i.idx)
        REG_BP0: next_s.bp_addr[0] = mov_i.wdata;
        REG_BP1: next_s.bp_addr[1] = mov_i.wdata;
        REG_BP2: next_s.bp_addr[2] = mov_i.wdata;
        REG_BP3: next_s.bp_addr[3] = mov_i.wdata;
        REG_STATUS: next_s.status = mov_i.wdata & STS_WMASK;
        REG_CONTROL: next_s.control = mov_i.wdata & CTL_WMASK;
        default: begin
        end
      endcase
    end
    // local enables drop on a task switch, globals kept
    if (task_switch_i) begin
      next_s.control = next_s.control & ~CTL_LOCAL_MASK;
    end
    // flags only ever set here; set wins over a software write
    if (exc_now) begin
      next_s.status = next_s.status | sts_set;
      next_s.control[CTL_GD_BIT] = 1'b0;
    end
    next_s.exc = exc_now;
    next_s.cause = cause;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // =========================================================
  // outputs
  assign mov_o = s.rsp;
  assign debug_exc_o = s.exc;
  assign cause_o = s.cause;

  // =========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_exc_taken;
    debug_exc_o;
  endsequence

  // software write that sets the single-step flag
  assign sts_bs_wr = mov_ok & mov_i.write & (mov_i.idx == REG_STATUS) &
                     mov_i.wdata[STS_BS_BIT];

  // code hit blocks issue and traps next cycle
  property p_code_before;
    insn_i.valid && code_hit |-> issue_block_o ##1 (s_exc_taken and cause_o.code);
  endproperty
  a_code_before: assert property (p_code_before)
    else $error("code breakpoint not taken before execution");

  property p_data_hit;
    data_i.valid && |(data_cond & bp_en) |=> s_exc_taken and cause_o.data;
  endproperty
  a_data_hit: assert property (p_data_hit)
    else $error("data breakpoint did not raise exception");

  // no enables and no other cause: a matching access stays silent
  property p_disabled_quiet;
    (s.control & (CTL_LOCAL_MASK | CTL_GLOBAL_MASK)) == 32'h0000_0000 && !insn_i.int3 &&
      !trap_flag_i && !task_trap_i && !gd_set |=> !debug_exc_o;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("exception without an armed cause");

  property p_priv;
    mov_i.valid && !priv_ok |=> mov_o.ack && mov_o.fault &&
      $stable(s.bp_addr) && mov_o.rdata == 32'h0000_0000;
  endproperty
  a_priv: assert property (p_priv)
    else $error("debug move allowed above privilege zero");

  property p_gd_block;
    mov_i.valid && priv_ok && gd_set |=> s_exc_taken and cause_o.gd &&
      !mov_o.ack && $stable(s.bp_addr);
  endproperty
  a_gd_block: assert property (p_gd_block)
    else $error("move not suppressed while access disabled");

  property p_gd_clear;
    debug_exc_o |-> !s.control[CTL_GD_BIT];
  endproperty
  a_gd_clear: assert property (p_gd_clear)
    else $error("access disable survived a debug exception");

  property p_step;
    retire_i && trap_flag_i |=> s_exc_taken and s.status[STS_BS_BIT] && cause_o.step;
  endproperty
  a_step: assert property (p_step)
    else $error("single step exception missing");

  property p_bs_cause;
    debug_exc_o && !cause_o.step && !$past(sts_bs_wr) && !$past(s.status[STS_BS_BIT])
      |-> !s.status[STS_BS_BIT];
  endproperty
  a_bs_cause: assert property (p_bs_cause)
    else $error("single-step flag set without single step");

  property p_task_trap;
    task_switch_i && task_trap_i |=> s_exc_taken and s.status[STS_BT_BIT];
  endproperty
  a_task_trap: assert property (p_task_trap)
    else $error("task-switch flag not set at handler entry");

  property p_task_enables;
    task_switch_i && !mov_i.valid |=> (s.control & CTL_LOCAL_MASK) == 32'h0000_0000 &&
      (s.control & CTL_GLOBAL_MASK) == ($past(s.control) & CTL_GLOBAL_MASK);
  endproperty
  a_task_enables: assert property (p_task_enables)
    else $error("enables wrong after task switch");

  property p_match_flags;
    exc_now |=> (s.status[NUM_BP-1:0] & $past(code_cond | data_cond)) ==
      $past(code_cond | data_cond);
  endproperty
  a_match_flags: assert property (p_match_flags)
    else $error("breakpoint match flag missing");

  property p_status_kept;
    !exc_now && !(mov_ok && mov_i.write && mov_i.idx == REG_STATUS) |=> $stable(s.status);
  endproperty
  a_status_kept: assert property (p_status_kept)
    else $error("status changed without cause");

  property p_int3;
    insn_i.valid && insn_i.int3 && !code_hit |=> s_exc_taken and cause_o.int3;
  endproperty
  a_int3: assert property (p_int3)
    else $error("trap instruction did not raise exception");

  property p_read_back;
    mov_ok && !mov_i.write && mov_i.idx == REG_CONTROL |=>
      mov_o.ack && mov_o.rdata == $past(s.control);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("control read returned wrong value");

  property p_mov_ack;
    mov_ok |=> mov_o.ack && !mov_o.fault;
  endproperty
  a_mov_ack: assert property (p_mov_ack)
    else $error("privileged move not acknowledged");

  property p_control_kept;
    !task_switch_i && !mov_ok && !exc_now |=> $stable(s.control);
  endproperty
  a_control_kept: assert property (p_control_kept)
    else $error("control changed without write, switch or exception");

endmodule : dbu_core

// ===== testbench/dbu_cpu_model.sv
`timescale 1ns/1ns
module dbu_cpu_model
  import dbu_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fetch request from the bench, issue block from the unit
  input wire dbu_insn_t fetch_i,
  input wire logic issue_block_i,
  // toward the unit
  output dbu_insn_t insn_o,
  output logic retire_o
);
  // ==========================================================
  // issue and retire
  // a blocked instruction is dropped and never retires
  assign insn_o = fetch_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      retire_o <= 1'b0;
    end else begin
      retire_o <= fetch_i.valid & ~issue_block_i;
    end
  end
endmodule : dbu_cpu_model

// ===== testbench/dbu_core_tb.sv
`timescale 1ns/1ns
module dbu_core_tb
  import dbu_pkg::*;
;
  logic clk_i, rst_i, retire_i, trap_flag_i, issue_block_o;
  logic task_switch_i, task_trap_i, debug_exc_o, hit;
  logic [1:0] cpl_i;
  dbu_mov_req_t mov_i;
  dbu_mov_rsp_t mov_o;
  dbu_insn_t fetch, insn_i;
  dbu_data_t data_i;
  dbu_cause_t cause_o;
  int err_total, n_checks;
  logic [31:0] seed, rd, a, v;
  logic [1:0] lens [4] = '{LEN_1, LEN_2, 2'h2, LEN_4};
  logic [1:0] types [5] = '{TYPE_EXEC, TYPE_WRITE, 2'h2, TYPE_RDWR, TYPE_RDWR};

  dbu_core dbu_core_i (.clk_i(clk_i), .rst_i(rst_i), .cpl_i(cpl_i), .mov_i(mov_i),
    .mov_o(mov_o), .insn_i(insn_i), .retire_i(retire_i), .trap_flag_i(trap_flag_i),
    .issue_block_o(issue_block_o), .data_i(data_i), .task_switch_i(task_switch_i),
    .task_trap_i(task_trap_i), .debug_exc_o(debug_exc_o), .cause_o(cause_o));
  dbu_cpu_model dbu_cpu_model_i (.clk_i(clk_i), .rst_i(rst_i), .fetch_i(fetch),
    .issue_block_i(issue_block_o), .insn_o(insn_i), .retire_o(retire_i));

  // ==========================================================
  // clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    test_done();
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] f_ctl(input int i, input logic [1:0] ty,
    input logic [1:0] ln, input logic l, input logic g);
    return (32'(ty) << (CTL_FLD_BASE + CTL_FLD_STRIDE * i))
      | (32'(ln) << (CTL_FLD_BASE + 2 + CTL_FLD_STRIDE * i))
      | (32'(l) << (CTL_EN_STRIDE * i)) | (32'(g) << (CTL_EN_STRIDE * i + 1));
  endfunction : f_ctl

  function automatic int f_span(input logic [1:0] ln);
    return (ln == LEN_4) ? 4 : ((ln == LEN_2) ? 2 : ((ln == LEN_1) ? 1 : 0));
  endfunction : f_span

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  task automatic test_done();
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // one move; exp_rsp is {ack, fault}
  task automatic mov(input logic w, input logic [2:0] ri, input logic [31:0] wd,
    input logic [1:0] cpl, input logic [1:0] exp_rsp, output logic [31:0] rdo);
    @(posedge clk_i);
    mov_i <= '{valid: 1'b1, write: w, idx: ri, wdata: wd};
    cpl_i <= cpl;
    @(posedge clk_i);
    mov_i <= '0;
    cpl_i <= 2'h0;
    #1;
    chk("mov_rsp", {30'h0, exp_rsp}, {30'h0, mov_o.ack, mov_o.fault});
    rdo = mov_o.rdata;
  endtask : mov

  task automatic wr(input logic [2:0] ri, input logic [31:0] wd);
    mov(1'b1, ri, wd, 2'h0, 2'h2, rd);
  endtask : wr

  task automatic rdc(input string nm, input logic [2:0] ri, input logic [31:0] exp);
    mov(1'b0, ri, 32'h0, 2'h0, 2'h2, rd);
    chk(nm, exp, rd);
  endtask : rdc

  // ends the one-cycle causes at the next edge and checks {exc, cause} just after that same edge
  task automatic fire(input logic [6:0] exp);
    @(posedge clk_i);
    fetch <= '0;
    data_i <= '0;
    task_switch_i <= 1'b0;
    task_trap_i <= 1'b0;
    #1;
    chk("exc", {25'h0, exp}, {25'h0, debug_exc_o, cause_o});
  endtask : fire

  // ==========================================================
  // main sequence
  initial begin
    rst_i = 1'b1;
    cpl_i = 2'h0;
    mov_i = '0;
    fetch = '0;
    data_i = '0;
    trap_flag_i = 1'b0;
    task_switch_i = 1'b0;
    task_trap_i = 1'b0;
    err_total = 0;
    n_checks = 0;
    seed = 32'h0000_0012;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) rdc("reset_value", 3'(i), 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      wr(3'(i), v);
      rdc("bp_addr", 3'(i), v);
    end
    v = rnd() & 32'hffff_dfff;
    wr(REG_CONTROL, v);
    rdc("control", REG_CONTROL, v & CTL_WMASK);
    v = rnd();
    wr(REG_STATUS, v);
    rdc("status", REG_STATUS, v & STS_WMASK);
    wr(3'h4, v);
    rdc("unmapped", 3'h4, 32'h0);
    wr(REG_CONTROL, 32'h0);
    wr(REG_BP0, v);
    for (int c = 1; c < 4; c++) mov(1'b1, REG_BP0, ~v, 2'(c), 2'h3, rd);
    rdc("bp0_kept", REG_BP0, v);
    // data breakpoint span for every length code
    a = rnd() & 32'hffff_fff0;
    wr(REG_BP2, a);
    for (int j = 0; j < 4; j++) begin
      wr(REG_CONTROL, f_ctl(2, TYPE_RDWR, lens[j], 1'b0, 1'b1));
      for (int k = 0; k < 5; k++) begin
        @(posedge clk_i);
        data_i <= '{valid: 1'b1, write: 1'b0, addr: a + 32'(k)};
        fire((k < f_span(lens[j])) ? 7'h41 : 7'h00);
      end
    end
    // every type code against reads and writes, then disabled
    for (int j = 0; j < 5; j++) begin
      wr(REG_CONTROL, f_ctl(2, types[j], LEN_1, j < 4, 1'b0));
      for (int w = 0; w < 2; w++) begin
        hit = (j < 4) && (types[j] == TYPE_RDWR || (w == 1 && types[j] == TYPE_WRITE));
        @(posedge clk_i);
        data_i <= '{valid: 1'b1, write: 1'(w), addr: a};
        fire(hit ? 7'h41 : 7'h00);
      end
    end
    // execute breakpoint with a disabled twin, then single-step
    wr(REG_STATUS, 32'h0);
    v = rnd();
    wr(REG_BP0, v);
    wr(REG_BP1, v);
    wr(REG_CONTROL, f_ctl(0, TYPE_EXEC, LEN_1, 1'b1, 1'b0));
    trap_flag_i <= 1'b1;
    @(posedge clk_i);
    fetch <= '{valid: 1'b1, int3: 1'b0, addr: v};
    #1;
    chk("issue_block", 32'h1, {31'h0, issue_block_o});
    fire(7'h60);
    fire(7'h00);
    @(posedge clk_i);
    fetch <= '{valid: 1'b1, int3: 1'b0, addr: v + 32'h10};
    fire(7'h00);
    fire(7'h48);
    trap_flag_i <= 1'b0;
    rdc("status", REG_STATUS, 32'h0000_4003);
    rdc("status_kept", REG_STATUS, 32'h0000_4003);
    // task switch into a trapping task
    wr(REG_CONTROL, 32'h0000_0019);
    @(posedge clk_i);
    task_switch_i <= 1'b1;
    task_trap_i <= 1'b1;
    fire(7'h44);
    rdc("control", REG_CONTROL, 32'h0000_0008);
    rdc("status", REG_STATUS, 32'h0000_c003);
    // access disable: move suppressed, then cleared by a trap instruction
    wr(REG_BP3, 32'h0);
    wr(REG_CONTROL, 32'h0000_2000);
    mov(1'b1, REG_BP3, rnd(), 2'h0, 2'h0, rd);
    chk("exc", 32'h0000_0042, {25'h0, debug_exc_o, cause_o});
    rdc("control", REG_CONTROL, 32'h0);
    rdc("bp3_kept", REG_BP3, 32'h0);
    wr(REG_CONTROL, 32'h0000_2000);
    @(posedge clk_i);
    fetch <= '{valid: 1'b1, int3: 1'b1, addr: rnd()};
    fire(7'h50);
    rdc("control", REG_CONTROL, 32'h0);
    test_done();
  end
endmodule : dbu_core_tb
